// ===== verilog/cmpc_pkg.sv
// Constants shared by the comparator control block and its output filter.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package cmpc_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 50;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [4:0]  IDX_CTL0  = 5'h00;
    localparam logic [4:0]  IDX_CTL1  = 5'h02;
    localparam logic [4:0]  IDX_CTL2  = 5'h04;
    localparam logic [4:0]  IDX_CTL3  = 5'h06;
    localparam logic [4:0]  IDX_INT   = 5'h0c;
    localparam logic [4:0]  IDX_IV    = 5'h0e;
    localparam logic [4:0]  IDX_IMASK = 5'h10;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] CTL0_RST   = 16'h0000;
    localparam logic [15:0] CTL1_RST   = 16'h0000;
    localparam logic [15:0] CTL2_RST   = 16'h0000;
    localparam logic [15:0] CTL3_RST   = 16'h0000;
    localparam logic [15:0] IMASK_RST  = 16'h0000;
    localparam logic [15:0] CTL0_WMASK = 16'h8f8f;
    localparam logic [15:0] CTL1_WMASK = 16'h1cfe;
    localparam logic [15:0] IMASK_WMASK = 16'h0001;
    localparam logic [15:0] IV_CODE_CMP = 16'h0002;
    localparam logic [15:0] IV_CODE_NONE = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          MINUS_EN_BIT  = 15;
    localparam int          MINUS_SEL_LSB = 8;
    localparam int          PLUS_EN_BIT   = 7;
    localparam int          PLUS_SEL_LSB  = 0;
    localparam int          MRVS_BIT      = 12;
    localparam int          MRVL_BIT      = 11;
    localparam int          ON_BIT        = 10;
    localparam int          FDLY_LSB      = 6;
    localparam int          EXCH_BIT      = 5;
    localparam int          SHORT_BIT     = 4;
    localparam int          IES_BIT       = 3;
    localparam int          FILT_BIT      = 2;
    localparam int          POL_BIT       = 1;
    localparam int          RESULT_BIT    = 0;
    localparam int          RSRC_LSB      = 6;
    localparam int          FLAG_BIT      = 0;
    localparam logic [1:0]  RSRC_NO_SWITCH = 2'b11;

    // ------------------------------------------------------------
    // Filter delay steps
    // ------------------------------------------------------------
    localparam int          FDLY0_NS = 450;
    localparam int          FDLY1_NS = 900;
    localparam int          FDLY2_NS = 1800;
    localparam int          FDLY3_NS = 3600;
    localparam int          FDLY0_CYC = FDLY0_NS / CLK_PERIOD_NS;
    localparam int          FDLY1_CYC = FDLY1_NS / CLK_PERIOD_NS;
    localparam int          FDLY2_CYC = FDLY2_NS / CLK_PERIOD_NS;
    localparam int          FDLY3_CYC = FDLY3_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

endpackage

// ===== verilog/cmpc_out_filter.sv
// Digital output filter: the output follows the input once it has held
// a new value for the selected number of cycles. Same clock as caller.
`timescale 1ns/1ns
`default_nettype none
module cmpc_out_filter (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       enable_i,
    input  wire logic [1:0] step_i,
    // Data
    input  wire logic       raw_i,
    output var  logic       out_o
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic       out_nxt;
    logic [6:0] limit;

    // ------------------------------------------------------------
    // Delay step decode
    // ------------------------------------------------------------
    function automatic logic [6:0] step_limit(input logic [1:0] s);
        case (s)
            2'b00:   step_limit = 7'(cmpc_pkg::FDLY0_CYC);
            2'b01:   step_limit = 7'(cmpc_pkg::FDLY1_CYC);
            2'b10:   step_limit = 7'(cmpc_pkg::FDLY2_CYC);
            default: step_limit = 7'(cmpc_pkg::FDLY3_CYC);
        endcase
    endfunction

    always_comb begin
        limit   = step_limit(step_i);
        cnt_nxt = 7'h00;
        out_nxt = out_o;
        if (!enable_i) begin
            out_nxt = raw_i;
        end else if (raw_i != out_o) begin
            if (cnt_r + 7'h01 >= limit) begin
                out_nxt = raw_i;
            end else begin
                cnt_nxt = cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_r <= 7'h00;
            out_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_o <= out_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_filter_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        enable_i && $past(enable_i) && $changed(out_o)
        |-> $past(cnt_r) + 7'h01 >= $past(limit))
        else $error("Filtered output changed before delay elapsed");

endmodule // cmpc_out_filter
`default_nettype wire

// ===== verilog/cmpc_regs.sv
// Comparator control registers with AXI4-Lite slave and interrupt.
// Assumes one 20 MHz clock; compare_raw_i comes from the analog domain.
//
// What this block does
// - Decode seven registers at their word offsets
// - Power-up clear resets all but control 3
// - Control 3 resets only on power-on
// - Vector word is read-only
// - Minus enable gates minus channel selector
// - Plus enable gates plus channel
// - Plus selector acts only while enabled
// - Flag set on selected result edge
// - Filter delay field picks four steps
// - Short bit shorts both terminals
// - Exchange swaps terminals, inverts output
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cmpc_regs (
    // Clock and resets
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        power_up_clear_i,
    // AXI4-Lite write
    input  wire logic [6:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [6:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog front end
    input  wire logic        compare_raw_i,
    output var  logic        minus_channel_enable_o,
    output var  logic [3:0]  minus_channel_select_o,
    output var  logic        plus_channel_enable_o,
    output var  logic [3:0]  plus_channel_select_o,
    output var  logic        input_short_switch_o,
    output var  logic        terminal_exchange_o,
    output var  logic        comparator_on_o,
    output var  logic        high_reference_sel_o,
    output var  logic [15:0] reference_control_o,
    output var  logic [15:0] port_buffer_disable_o,
    // Status
    output var  logic        compare_result_o,
    output var  logic        irq_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [4:0] idx);
        case (idx)
            cmpc_pkg::IDX_CTL0, cmpc_pkg::IDX_CTL1, cmpc_pkg::IDX_CTL2,
            cmpc_pkg::IDX_CTL3, cmpc_pkg::IDX_INT, cmpc_pkg::IDX_IV,
            cmpc_pkg::IDX_IMASK: is_mapped = 1'b1;
            default:             is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [1:0]  strb,
                                          input logic [15:0] wmask);
        logic [15:0] m;
        m     = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old & ~m) | (data & m);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] ctl0_r, ctl0_nxt, ctl1_r, ctl1_nxt;
    logic [15:0] ctl2_r, ctl2_nxt, ctl3_r, ctl3_nxt;
    logic [15:0] imask_r, imask_nxt;
    logic        flag_r, flag_nxt, prev_r, irq_nxt;
    logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [4:0]  widx_r, widx_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [1:0]  wstrb_r, wstrb_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        sync1_r, sync2_r;
    logic        filt_in, result;
    logic        wr_go, set_ev, clr_ev, ref_hi;
    logic [15:0] ctl1_view, iv_view, rd_word;
    logic [4:0]  ridx;

    // ------------------------------------------------------------
    // Comparator output path
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= compare_raw_i;
            sync2_r <= sync1_r;
        end
    end

    // Exchange inverts the result; polarity inverts again
    assign filt_in = sync2_r ^ ctl1_r[cmpc_pkg::EXCH_BIT]
                   ^ ctl1_r[cmpc_pkg::POL_BIT];

    cmpc_out_filter u_filter (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .enable_i (ctl1_r[cmpc_pkg::FILT_BIT]),
        .step_i   (ctl1_r[cmpc_pkg::FDLY_LSB +: 2]),
        .raw_i    (filt_in),
        .out_o    (result)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    assign ridx      = s_axi_araddr[6:2];
    assign ctl1_view = ctl1_r | {15'h0000, result};
    assign iv_view   = flag_r ? cmpc_pkg::IV_CODE_CMP
                              : cmpc_pkg::IV_CODE_NONE;
    assign wr_go     = aw_held_r & w_held_r & ~bvalid_r;

    always_comb begin
        case (ridx)
            cmpc_pkg::IDX_CTL0:  rd_word = ctl0_r;
            cmpc_pkg::IDX_CTL1:  rd_word = ctl1_view;
            cmpc_pkg::IDX_CTL2:  rd_word = ctl2_r;
            cmpc_pkg::IDX_CTL3:  rd_word = ctl3_r;
            cmpc_pkg::IDX_INT:   rd_word = {15'h0000, flag_r};
            cmpc_pkg::IDX_IV:    rd_word = iv_view;
            cmpc_pkg::IDX_IMASK: rd_word = imask_r;
            default:             rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        // Bus channels
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        widx_nxt    = widx_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            widx_nxt    = s_axi_awaddr[6:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata[15:0];
            wstrb_nxt  = s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_go) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = is_mapped(widx_r) ? cmpc_pkg::RESP_OKAY
                                            : cmpc_pkg::RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = {16'h0000, rd_word};
            rresp_nxt  = is_mapped(ridx) ? cmpc_pkg::RESP_OKAY
                                         : cmpc_pkg::RESP_SLVERR;
        end

        // Registers; vector word has no write path
        ctl0_nxt  = ctl0_r;
        ctl1_nxt  = ctl1_r;
        ctl2_nxt  = ctl2_r;
        ctl3_nxt  = ctl3_r;
        imask_nxt = imask_r;
        clr_ev    = 1'b0;
        if (wr_go) begin
            case (widx_r)
                cmpc_pkg::IDX_CTL0: ctl0_nxt = merge(ctl0_r, wdata_r,
                    wstrb_r, cmpc_pkg::CTL0_WMASK);
                cmpc_pkg::IDX_CTL1: ctl1_nxt = merge(ctl1_r, wdata_r,
                    wstrb_r, cmpc_pkg::CTL1_WMASK);
                cmpc_pkg::IDX_CTL2: ctl2_nxt = merge(ctl2_r, wdata_r,
                    wstrb_r, 16'hffff);
                cmpc_pkg::IDX_CTL3: ctl3_nxt = merge(ctl3_r, wdata_r,
                    wstrb_r, 16'hffff);
                cmpc_pkg::IDX_IMASK: imask_nxt = merge(imask_r, wdata_r,
                    wstrb_r, cmpc_pkg::IMASK_WMASK);
                cmpc_pkg::IDX_INT: clr_ev = wstrb_r[0]
                                          & wdata_r[cmpc_pkg::FLAG_BIT];
                default: clr_ev = 1'b0;
            endcase
        end

        // Edge flag, set wins over clear
        set_ev = ctl1_r[cmpc_pkg::IES_BIT] ? (prev_r & ~result)
                                           : (~prev_r & result);
        flag_nxt = (flag_r & ~clr_ev) | set_ev;

        // Power-up clear leaves control 3 alone
        if (power_up_clear_i) begin
            ctl0_nxt  = cmpc_pkg::CTL0_RST;
            ctl1_nxt  = cmpc_pkg::CTL1_RST;
            ctl2_nxt  = cmpc_pkg::CTL2_RST;
            imask_nxt = cmpc_pkg::IMASK_RST;
            flag_nxt  = 1'b0;
        end
        irq_nxt = flag_nxt & imask_nxt[cmpc_pkg::FLAG_BIT];

        // Reference level choice
        if (ctl2_r[cmpc_pkg::RSRC_LSB +: 2] == cmpc_pkg::RSRC_NO_SWITCH) begin
            ref_hi = 1'b0;
        end else if (ctl1_r[cmpc_pkg::MRVS_BIT]) begin
            ref_hi = ctl1_r[cmpc_pkg::MRVL_BIT];
        end else begin
            ref_hi = result;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctl0_r    <= cmpc_pkg::CTL0_RST;
            ctl1_r    <= cmpc_pkg::CTL1_RST;
            ctl2_r    <= cmpc_pkg::CTL2_RST;
            ctl3_r    <= cmpc_pkg::CTL3_RST;
            imask_r   <= cmpc_pkg::IMASK_RST;
            flag_r    <= 1'b0;
            prev_r    <= 1'b0;
            irq_o     <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            widx_r    <= 5'h00;
            wdata_r   <= 16'h0000;
            wstrb_r   <= 2'b00;
            bvalid_r  <= 1'b0;
            bresp_r   <= cmpc_pkg::RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= cmpc_pkg::RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
            minus_channel_enable_o <= 1'b0;
            minus_channel_select_o <= 4'h0;
            plus_channel_enable_o  <= 1'b0;
            plus_channel_select_o  <= 4'h0;
            high_reference_sel_o   <= 1'b0;
        end else begin
            ctl0_r    <= ctl0_nxt;
            ctl1_r    <= ctl1_nxt;
            ctl2_r    <= ctl2_nxt;
            ctl3_r    <= ctl3_nxt;
            imask_r   <= imask_nxt;
            flag_r    <= flag_nxt;
            prev_r    <= result;
            irq_o     <= irq_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            widx_r    <= widx_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            minus_channel_enable_o <= ctl0_r[cmpc_pkg::MINUS_EN_BIT];
            minus_channel_select_o <= ctl0_r[cmpc_pkg::MINUS_EN_BIT]
                ? ctl0_r[cmpc_pkg::MINUS_SEL_LSB +: 4] : 4'h0;
            plus_channel_enable_o  <= ctl0_r[cmpc_pkg::PLUS_EN_BIT];
            plus_channel_select_o  <= ctl0_r[cmpc_pkg::PLUS_EN_BIT]
                ? ctl0_r[cmpc_pkg::PLUS_SEL_LSB +: 4] : 4'h0;
            high_reference_sel_o   <= ref_hi;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready         = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready          = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid          = bvalid_r;
    assign s_axi_bresp           = bresp_r;
    assign s_axi_arready         = ~rvalid_r;
    assign s_axi_rvalid          = rvalid_r;
    assign s_axi_rdata           = rdata_r;
    assign s_axi_rresp           = rresp_r;
    assign input_short_switch_o  = ctl1_r[cmpc_pkg::SHORT_BIT];
    assign terminal_exchange_o   = ctl1_r[cmpc_pkg::EXCH_BIT];
    assign comparator_on_o       = ctl1_r[cmpc_pkg::ON_BIT];
    assign reference_control_o   = ctl2_r;
    assign port_buffer_disable_o = ctl3_r;
    assign compare_result_o      = result;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_ctl1_decode: assert property (
        s_axi_arvalid && s_axi_arready && ridx == cmpc_pkg::IDX_CTL1
        |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(ctl1_view)})
        else $error("Control 1 read returned wrong word");
    a_puc_clears: assert property (
        power_up_clear_i |=> ctl0_r == 16'h0000 && ctl1_r == 16'h0000
                             && !flag_r && !irq_o)
        else $error("Power-up clear left state behind");
    a_puc_keeps3: assert property (
        power_up_clear_i && !(wr_go && widx_r == cmpc_pkg::IDX_CTL3)
        |=> $stable(ctl3_r))
        else $error("Power-up clear changed control 3");
    a_vector_ro: assert property (
        wr_go && widx_r == cmpc_pkg::IDX_IV && !set_ev
        |=> flag_r == $past(flag_r) || $past(power_up_clear_i))
        else $error("Write to vector word changed state");
    a_minus_gate: assert property (
        !ctl0_r[cmpc_pkg::MINUS_EN_BIT]
        |=> !minus_channel_enable_o && minus_channel_select_o == 4'h0)
        else $error("Minus channel routed while disabled");
    a_plus_gate: assert property (
        ctl0_r[cmpc_pkg::PLUS_EN_BIT]
        |=> plus_channel_enable_o
            && plus_channel_select_o == $past(ctl0_r[3:0]))
        else $error("Plus channel not routed while enabled");
    a_ref_manual: assert property (
        ctl1_r[cmpc_pkg::MRVS_BIT] && ctl2_r[7:6] != 2'b11
        |=> high_reference_sel_o == $past(ctl1_r[cmpc_pkg::MRVL_BIT]))
        else $error("Manual reference level not applied");
    a_reserved_zero: assert property (
        (ctl0_r & ~cmpc_pkg::CTL0_WMASK) == 16'h0000
        && (ctl1_r & ~cmpc_pkg::CTL1_WMASK) == 16'h0000)
        else $error("Reserved bit became set");
    a_edge_flag: assert property (
        !ctl1_r[cmpc_pkg::IES_BIT] && $rose(result) && !power_up_clear_i
        |=> flag_r)
        else $error("Rising edge did not set flag");
    a_irq_level: assert property (
        irq_o == (flag_r && imask_r[cmpc_pkg::FLAG_BIT]))
        else $error("Interrupt level differs from masked flag");

    c_flag_set:  cover property ($rose(flag_r));
    c_wr_ctl0:   cover property (wr_go && widx_r == cmpc_pkg::IDX_CTL0);
    c_rd_vector: cover property (s_axi_arvalid && s_axi_arready
                                 && ridx == cmpc_pkg::IDX_IV);

endmodule // cmpc_regs
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the comparator control registers.
// Assumes cmpc_pkg and cmpc_regs are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
`define A(i) {cmpc_pkg::i, 2'b00}
module tb_top;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    typedef struct packed {
        logic [6:0]  a;
        logic [15:0] w;
        logic [15:0] r;
        logic [1:0]  s;
    } cmpc_row_t;
    logic        clock_i = 0, rst_n_i = 0, power_up_clear_i = 0, raw = 0;
    logic [6:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, ok, se;
    logic        m_en, p_en, shrt, exch, on, hiref, result, irq;
    logic [3:0]  m_sel, p_sel;
    logic [15:0] refc, pbd;
    int          failures = 0, checks_done = 0, cycles = 0;
    cmpc_row_t   rows [10];

    cmpc_regs cmpc_regs_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .power_up_clear_i(power_up_clear_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .compare_raw_i(raw),
        .minus_channel_enable_o(m_en), .minus_channel_select_o(m_sel),
        .plus_channel_enable_o(p_en), .plus_channel_select_o(p_sel),
        .input_short_switch_o(shrt), .terminal_exchange_o(exch),
        .comparator_on_o(on), .high_reference_sel_o(hiref),
        .reference_control_o(refc), .port_buffer_disable_o(pbd),
        .compare_result_o(result), .irq_o(irq));

    // ----------------------------------------------------------
    // Clock, timeout and bus tasks
    // ----------------------------------------------------------
    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    task end_of_test;
        if (failures == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] e);
        @(posedge clock_i);
        awaddr <= a; awvalid <= 1; wdata <= {16'h0, d}; wstrb <= 4'h3;
        wvalid <= 1; bready <= 1;
        while (1) begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid === 1'b1) begin
                `CHK(bresp, e);
                bready <= 0;
                break;
            end
        end
    endtask
    task rd(input logic [6:0] a, input logic [15:0] e, input logic [1:0] s);
        @(posedge clock_i);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (1) begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid === 1'b1) begin
                `CHK(rdata, {16'h0, e});
                `CHK(rresp, s);
                rready <= 0;
                break;
            end
        end
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        ok = cmpc_pkg::RESP_OKAY;
        se = cmpc_pkg::RESP_SLVERR;
        rows = '{'{`A(IDX_CTL0), 16'hffff, 16'h8f8f, ok},
                 '{`A(IDX_CTL1), 16'hffff, 16'h1cfe, ok},
                 '{`A(IDX_CTL1), 16'h0000, 16'h0000, ok},
                 '{`A(IDX_CTL2), 16'ha5c3, 16'ha5c3, ok},
                 '{`A(IDX_CTL3), 16'h5a3c, 16'h5a3c, ok},
                 '{`A(IDX_IV), 16'hffff, 16'h0000, ok},
                 '{`A(IDX_IMASK), 16'hffff, 16'h0001, ok},
                 '{`A(IDX_INT), 16'h0000, 16'h0000, ok},
                 '{7'h7c, 16'h1234, 16'h0000, se},
                 '{`A(IDX_CTL0), 16'h8f7a, 16'h8f0a, ok}};
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1;
        foreach (rows[i]) rd(rows[i].a, 16'h0000, rows[i].s);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w, rows[i].s);
            rd(rows[i].a, rows[i].r, rows[i].s);
        end
        `CHK({m_en, m_sel, p_en, p_sel}, 10'h3e0);
        wr(`A(IDX_CTL0), 16'h0a8c, ok);
        @(posedge clock_i);
        `CHK({m_en, m_sel, p_en, p_sel}, 10'h01c);
        wr(`A(IDX_CTL2), 16'h0000, ok);
        wr(`A(IDX_CTL1), 16'h1800, ok);
        repeat (2) @(posedge clock_i);
        `CHK(hiref, 1'b1);
        wr(`A(IDX_CTL1), 16'h0010, ok);
        raw <= 1;
        repeat (6) @(posedge clock_i);
        `CHK({result, irq, hiref, shrt}, 4'hf);
        rd(`A(IDX_IV), cmpc_pkg::IV_CODE_CMP, ok);
        wr(`A(IDX_INT), 16'h0001, ok);
        rd(`A(IDX_INT), 16'h0000, ok);
        wr(`A(IDX_CTL1), 16'h0008, ok);
        raw <= 0;
        repeat (6) @(posedge clock_i);
        rd(`A(IDX_INT), 16'h0001, ok);
        wr(`A(IDX_CTL1), 16'h0029, ok);
        repeat (6) @(posedge clock_i);
        `CHK({result, exch}, 2'b11);
        rd(`A(IDX_CTL1), 16'h0029, ok);
        wr(`A(IDX_CTL1), 16'h0024, ok);
        raw <= 1;
        repeat (10) @(posedge clock_i);
        `CHK(result, 1'b1);
        repeat (2) @(posedge clock_i);
        `CHK(result, 1'b0);
        wr(`A(IDX_IMASK), 16'h0000, ok);
        `CHK(irq, 1'b0);
        @(posedge clock_i);
        power_up_clear_i <= 1;
        @(posedge clock_i);
        power_up_clear_i <= 0;
        rd(`A(IDX_CTL0), 16'h0000, ok);
        rd(`A(IDX_CTL3), 16'h5a3c, ok);
        @(posedge clock_i);
        rst_n_i <= 0;
        @(posedge clock_i);
        rst_n_i <= 1;
        rd(`A(IDX_CTL3), 16'h0000, ok);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
